// ---- core/remote_ctrl_simple.v ----
// Simple-mode remote-control command sequencer of the programmer
//
// Overview of operation
// - Commands count only once link_present has been high for 1 ms.
// - After an area change, busy rises within 8 s of the command falling.
// - Without an area change, busy rises within 50 ms of the command.
// - After acknowledge falls the set result flag drops within 50 ms.
`include "remote_ctrl_defs.vh"
module remote_ctrl_simple #(
  parameter MS_CYCLES = `MS_TICK_CYCLES,
  parameter AREA_BUSY_MS = `BUSY_MAX_AREA_MS,
  parameter PLAIN_BUSY_MS = `BUSY_MAX_PLAIN_MS
) (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // Controller command pins, active low
  input wire abort_n_i,
  input wire confirm_n_i,
  input wire advance_n_i,
  input wire verify_command_n_i,
  input wire run_n_i,
  input wire result_ack_n_i,
  // Link from the programmer side
  input wire link_up_i,
  // Programming engine handshake
  input wire job_done_i,
  input wire job_pass_i,
  output reg job_start_o,
  output reg [2:0] job_cmd_o,
  output reg job_abort_o,
  output reg area_step_o,
  // Status to the controller
  output reg link_present_o,
  output reg busy_o,
  output reg success_flag_o,
  output reg failure_flag_o
);
  // One-hot sequencer states
  localparam ST_IDLE = 4'h1;
  localparam ST_WAIT = 4'h2;
  localparam ST_BUSY = 4'h4;
  localparam ST_RESULT = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  // The divider free-runs from reset, so every delay below is counted in
  // whole ticks and is only exact to one ms; the link settle therefore counts
  // one tick more than its figure, while the pulse width counts only MIN_MS ticks.
  reg [15:0] div;
  wire ms_tick = (div == MS_CYCLES[15:0] - 16'h0001);
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      div <= 16'h0000;
    else if (ms_tick)
      div <= 16'h0000;
    else
      div <= div + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Link presence and settle time before commands are acknowledged
  // A link drop clears readiness at once, so a command held across a
  // reconnection must be given again in full before it counts.
  reg [1:0] settle_ms;
  reg link_ready;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_present_o <= 1'b0;
      settle_ms <= 2'h0;
      link_ready <= 1'b0;
    end else begin
      link_present_o <= link_up_i;
      if (!link_present_o) begin
        settle_ms <= 2'h0;
        link_ready <= 1'b0;
      end else if (ms_tick && !link_ready) begin
        // Count two ticks so at least one full ms has elapsed
        settle_ms <= settle_ms + 2'h1;
        if (settle_ms == `LINK_SETTLE_MS)
          link_ready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Qualified command events, one qualifier per pin
  // Each pin has its own counter, so two pins low together are both seen
  // and the sequencer alone decides which one it obeys. The five-cycle
  // latency is nothing against the ms figures and rides out a bouncing
  // release.
  wire [5:0] pins_n = {result_ack_n_i, abort_n_i, advance_n_i, run_n_i,
                       verify_command_n_i, confirm_n_i};
  wire [5:0] fell;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_q
      cmd_qualifier #(.MIN_MS(`PULSE_MIN_MS)) u_q (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ms_tick_i(ms_tick),
        .enable_i(link_ready),
        .cmd_n_i(pins_n[g]),
        .fall_o(fell[g])
      );
    end
  endgenerate
  // Confirm, verify and run start a job; the other three pins are
  // handled on their own by the sequencer
  wire job_req = fell[0] | fell[1] | fell[2];

  // Pick the command code of the first job event found
  // Pins are expected one at a time; if two release together, verify
  // beats run, run beats confirm, and the loser is dropped
  function [2:0] job_code;
    input [5:0] f;
    begin
      if (f[1])
        job_code = `CMD_VERIFY;
      else if (f[2])
        job_code = `CMD_RUN;
      else if (f[0])
        job_code = `CMD_CONFIRM;
      else
        job_code = `CMD_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  // IDLE   waits for a qualified command; advance only marks an area change
  // WAIT   holds the chosen job until the next tick raises busy
  // BUSY   runs until the engine reports done or abort is released
  // RESULT shows one flag until result acknowledge is released
  reg [3:0] state;
  reg area_changed;
  reg [13:0] wait_ms;
  // Busy is raised well inside the limit: at most one ms after the
  // command is seen, whichever limit applies, trading no latency cost
  wire [13:0] busy_limit = area_changed ? AREA_BUSY_MS[13:0]
                                        : PLAIN_BUSY_MS[13:0];
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      area_changed <= 1'b0;
      wait_ms <= 14'h0000;
      busy_o <= 1'b0;
      success_flag_o <= 1'b0;
      failure_flag_o <= 1'b0;
      job_start_o <= 1'b0;
      job_cmd_o <= `CMD_NONE;
      job_abort_o <= 1'b0;
      area_step_o <= 1'b0;
    end else begin
      job_start_o <= 1'b0;
      job_abort_o <= 1'b0;
      area_step_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Advance beats a job released in the same cycle; that job is lost
          if (fell[3]) begin
            area_changed <= 1'b1;
            area_step_o <= 1'b1;
          end else if (job_req) begin
            job_cmd_o <= job_code(fell);
            wait_ms <= 14'h0000;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Raise busy on the next tick, always below busy_limit
          // Releases while waiting are ignored; only the first job runs
          if (ms_tick || wait_ms >= busy_limit) begin
            busy_o <= 1'b1;
            job_start_o <= 1'b1;
            area_changed <= 1'b0;
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // Abort goes first so a done in the same cycle cannot report a pass
          // Flags are set only here and cleared only in RESULT or the default
          // branch, so a set and a clear can never fall in one cycle.
          if (fell[4]) begin
            job_abort_o <= 1'b1;
            busy_o <= 1'b0;
            failure_flag_o <= 1'b1;
            state <= ST_RESULT;
          end else if (job_done_i) begin
            busy_o <= 1'b0;
            success_flag_o <= job_pass_i;
            failure_flag_o <= !job_pass_i;
            state <= ST_RESULT;
          end
        end
        ST_RESULT: begin
          // Acknowledge is trusted to come after the buzzer gap
          // Flags stand however long the controller waits to clear them
          if (fell[5]) begin
            success_flag_o <= 1'b0;
            failure_flag_o <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          // An unused state code returns to idle with busy and both result flags low
          state <= ST_IDLE;
          busy_o <= 1'b0;
          success_flag_o <= 1'b0;
          failure_flag_o <= 1'b0;
          area_changed <= 1'b0;
        end
      endcase
    end
  end
endmodule // remote_ctrl_simple

// ---- core/remote_ctrl_defs.vh ----
// Timing constants for the simple-mode remote-control sequencer
`ifndef REMOTE_CTRL_DEFS_VH
`define REMOTE_CTRL_DEFS_VH
// System clock rate in kHz; one millisecond tick is derived from it
`define CLK_KHZ 20000
`define MS_TICK_CYCLES (`CLK_KHZ)
// Minimum accepted low width of a command, ms
`define PULSE_MIN_MS 50
// Settle time after link_present rises, ms
`define LINK_SETTLE_MS 1
// Busy must rise within these limits after a command falls, ms
`define BUSY_MAX_AREA_MS 8000
`define BUSY_MAX_PLAIN_MS 50
// Result flags must drop within this after acknowledge falls, ms
`define RESULT_DROP_MAX_MS 50
// Command codes
`define CMD_NONE 3'h0
`define CMD_CONFIRM 3'h1
`define CMD_VERIFY 3'h2
`define CMD_RUN 3'h3
`define CMD_ADVANCE 3'h4
`define CMD_ABORT 3'h5
`define CMD_RESULT_ACK 3'h6
`endif

// ---- core/cmd_qualifier.v ----
// Synchroniser and minimum-width qualifier for one active-low command pin
`include "remote_ctrl_defs.vh"
module cmd_qualifier #(
  parameter MIN_MS = `PULSE_MIN_MS
) (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // Millisecond tick and gate
  input wire ms_tick_i,
  input wire enable_i,
  // Pin and qualified event
  input wire cmd_n_i,
  output reg fall_o
);
  reg [2:0] sync;
  reg stable_n;
  reg [7:0] low_ms;
  reg long_enough;

  // Three stages; only the agreeing last two decide a change
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync <= 3'h7;
      stable_n <= 1'b1;
    end else begin
      sync <= {sync[1:0], cmd_n_i};
      if (sync[1] == sync[2])
        stable_n <= sync[2];
    end
  end

  // Count low time in ms; fire on release after a long enough pulse
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_ms <= 8'h00;
      long_enough <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      fall_o <= 1'b0;
      if (stable_n || !enable_i) begin
        fall_o <= long_enough && enable_i && stable_n;
        low_ms <= 8'h00;
        long_enough <= 1'b0;
      end else if (ms_tick_i && !long_enough) begin
        low_ms <= low_ms + 8'h01;
        if (low_ms + 8'h01 >= MIN_MS[7:0])
          long_enough <= 1'b1;
      end
    end
  end
endmodule // cmd_qualifier

// ---- bench/remote_ctrl_simple_asserts.sv ----
// Port-level assertions for the simple-mode remote-control sequencer
module remote_ctrl_simple_asserts #(parameter int MS_CYCLES = 20) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Command pins and engine answer
  input wire logic confirm_n_i,
  input wire logic verify_command_n_i,
  input wire logic run_n_i,
  input wire logic advance_n_i,
  input wire logic result_ack_n_i,
  input wire logic job_done_i,
  // Status outputs
  input wire logic job_start_o,
  input wire logic link_present_o,
  input wire logic busy_o,
  input wire logic success_flag_o,
  input wire logic failure_flag_o
);
  localparam int LIM = 50 * MS_CYCLES;
  localparam int LONG = 51 * MS_CYCLES;
  int cmd_low;
  int ack_low;
  int link_up;
  logic area;
  wire logic all_hi = confirm_n_i & verify_command_n_i & run_n_i;
  wire logic idle = !busy_o && !success_flag_o && !failure_flag_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////
  // Pulse lengths and link age; area marks a pending slow 8 s start
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_low <= 0;
      ack_low <= 0;
      link_up <= 0;
      area <= 1'b0;
    end else begin
      cmd_low <= all_hi ? 0 : cmd_low + 1;
      ack_low <= result_ack_n_i ? 0 : ack_low + 1;
      link_up <= link_present_o ? link_up + 1 : 0;
      area <= !advance_n_i | (area & !busy_o);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_busy_prompt: assert property (
    $rose(all_hi) && cmd_low >= LONG && idle && !area
    && link_up > cmd_low + 2 * MS_CYCLES |-> ##[1:LIM] busy_o)
    else $error("busy late after command");
  a_ack_drop: assert property ($rose(result_ack_n_i) && ack_low >= LONG
    && link_up > ack_low + 2 * MS_CYCLES
    |-> ##[1:LIM] !success_flag_o && !failure_flag_o)
    else $error("result flag held after acknowledge");
  a_link_settle: assert property (
    $rose(busy_o) |-> link_up >= MS_CYCLES)
    else $error("busy before link settled");
  a_start_busy: assert property (job_start_o |-> $rose(busy_o))
    else $error("start without busy rising");
  a_one_flag: assert property (!(success_flag_o && failure_flag_o))
    else $error("both result flags set");
  a_done_flag: assert property (busy_o && job_done_i
    |=> !busy_o && (success_flag_o ^ failure_flag_o))
    else $error("no single flag after done");
  c_start: cover property (job_start_o);
  c_pass: cover property ($rose(success_flag_o));
  c_fail: cover property ($rose(failure_flag_o));
endmodule // remote_ctrl_simple_asserts

// ---- bench/engine_model.sv ----
// Behavioural programming engine that answers job starts
module engine_model (
  // Clock and job handshake
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic abort_i,
  // Scenario controls
  input wire logic stall_i,
  input wire logic pass_i,
  // Answer to the sequencer
  output logic done_o,
  output logic pass_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  // Finishes 101 cycles after start unless stalled; abort drops the job
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (start_i) cnt <= 100;
    else if (abort_i) cnt <= -1;
    else if (cnt > 0 && !stall_i) cnt <= cnt - 1;
    else if (cnt == 0) begin
      done_o <= 1'b1;
      cnt <= -1;
    end
  end
  // Outcome is only valid with done; otherwise show the opposite
  assign pass_o = done_o ? pass_i : !pass_i;
endmodule // engine_model

// ---- bench/remote_ctrl_simple_tb.sv ----
// Self-checking bench for the simple-mode remote-control sequencer
module remote_ctrl_simple_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] pin; logic pass; logic [2:0] code;} row_t;
  row_t rows [3] = '{'{3'h1, 1'b1, 3'h1}, '{3'h3, 1'b0, 3'h2},
    '{3'h4, 1'b1, 3'h3}};
  logic clk_i = 0;
  logic arst_n_i = 0;
  logic [5:0] cmd_n = 6'h3f; // abort confirm advance verify run ack
  logic link_up = 0;
  logic stall = 0;
  logic pass = 0;
  logic job_done, job_pass, job_start, job_abort;
  logic [2:0] job_cmd;
  logic busy_o, success_flag_o, failure_flag_o;
  logic link_present, area_step;
  int n_area_step = 0;
  int n_mismatch = 0;
  int checks = 0;
  remote_ctrl_simple #(.MS_CYCLES(20)) remote_ctrl_simple_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .abort_n_i(cmd_n[0]),
    .confirm_n_i(cmd_n[1]), .advance_n_i(cmd_n[2]),
    .verify_command_n_i(cmd_n[3]), .run_n_i(cmd_n[4]),
    .result_ack_n_i(cmd_n[5]), .link_up_i(link_up), .job_done_i(job_done),
    .job_pass_i(job_pass), .job_start_o(job_start), .job_cmd_o(job_cmd),
    .job_abort_o(job_abort), .area_step_o(area_step),
    .link_present_o(link_present), .busy_o(busy_o),
    .success_flag_o(success_flag_o), .failure_flag_o(failure_flag_o));
  engine_model engine_model_inst (.clk_i(clk_i), .start_i(job_start),
    .abort_i(job_abort), .stall_i(stall), .pass_i(pass),
    .done_o(job_done), .pass_o(job_pass));
  initial forever #25 clk_i = ~clk_i;
  // Counts area_step_o pulses; one is due per accepted advance
  always @(posedge clk_i) begin
    if (area_step)
      n_area_step <= n_area_step + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic exp, input logic got);
    checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  // Holds one pin low for the given milliseconds
  task automatic pulse(input int pin, input int ms);
    cmd_n[pin] <= 1'b0;
    repeat (ms * 20) @(posedge clk_i);
    cmd_n[pin] <= 1'b1;
  endtask
  task automatic wait_busy(input logic v, input int lim);
    int n = 0;
    while (busy_o !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check("busy", v, busy_o);
  endtask
  // Result check, acknowledge after the 1 ms gap, flags gone by 50 ms
  task automatic finish(input logic ok);
    wait_busy(1'b0, 400);
    check("success", ok, success_flag_o);
    check("failure", !ok, failure_flag_o);
    repeat (20) @(posedge clk_i);
    pulse(5, 52);
    repeat (1000) @(posedge clk_i);
    check("flags", 1'b0, success_flag_o | failure_flag_o);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    check("idle busy", 1'b0, busy_o | success_flag_o | failure_flag_o);
    // A long press made mostly before the link came up must not count
    cmd_n[4] <= 1'b0;
    repeat (940) @(posedge clk_i);
    link_up <= 1'b1;
    repeat (100) @(posedge clk_i);
    check("link_present", 1'b1, link_present);
    cmd_n[4] <= 1'b1;
    repeat (1100) @(posedge clk_i);
    check("busy early", 1'b0, busy_o);
    pulse(3, 40);
    repeat (1100) @(posedge clk_i);
    check("busy short", 1'b0, busy_o);
    for (int i = 0; i < 3; i++) begin
      pass <= rows[i].pass;
      pulse(rows[i].pin, 52);
      wait_busy(1'b1, 1000);
      for (int b = 0; b < 3; b++) begin
        check("cmd", rows[i].code[b], job_cmd[b]);
      end
      finish(rows[i].pass);
    end
    // Area change: advance, the 1 ms gap, then verify
    pass <= 1'b1;
    pulse(2, 52);
    repeat (20) @(posedge clk_i);
    pulse(3, 52);
    wait_busy(1'b1, 160000);
    check("area step", 1'b1, n_area_step == 1);
    finish(1'b1);
    // Abort while the engine stalls ends with the failure flag
    stall <= 1'b1;
    pulse(4, 52);
    wait_busy(1'b1, 1000);
    pulse(0, 52);
    finish(1'b0);
    // Reset in mid-job clears every status and forces a new link settle
    pulse(4, 52);
    wait_busy(1'b1, 1000);
    arst_n_i <= 1'b0;
    stall <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("reset", 1'b0, busy_o | success_flag_o | failure_flag_o);
    check("link reset", 1'b0, link_present);
    arst_n_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    pulse(1, 52);
    wait_busy(1'b1, 1000);
    finish(1'b1);
    print_verdict;
  end
endmodule // remote_ctrl_simple_tb

bind remote_ctrl_simple remote_ctrl_simple_asserts #(.MS_CYCLES(MS_CYCLES))
  chk_inst (.clk_i, .arst_n_i, .confirm_n_i, .verify_command_n_i, .run_n_i,
  .advance_n_i, .result_ack_n_i, .job_done_i, .job_start_o, .link_present_o,
  .busy_o, .success_flag_o, .failure_flag_o);
